// ===== src/chs_port.sv
// Coprocessor clock, strobe and ready logic for full or half speed
//
// How it works
// RL1: Full speed: coprocessor double clock follows the primary double clock.
// RL2: Half speed: coprocessor double clock runs at half primary frequency.
// RL3: Full speed: coprocessor phase clock follows the system phase clock.
// RL4: Half speed: phase clock at half rate, high in phase 2.
// RL5: Board synchronises coprocessor reset to the coprocessor double clock.
// RL6: Half speed: address strobe out to coprocessor; unused at full speed.
// RL7: Coprocessor ready input paces forwarded cycles in half speed.
// RL8: Half speed: CPU ready is built from the coprocessor ready.
// RL9: Full speed: board wires coprocessor ready straight to CPU ready logic.
// RL10: Speed mode is a static setting, taken only between cycles.
`timescale 1ns/1ns

module chs_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Clocks from the system
  input wire logic primaryDoubleClock,
  input wire logic sysPhaseClock,
  // CPU local bus
  input wire logic cpuAddrStrobeN,
  output logic cpuReadyFromCoproN,
  // Coprocessor side
  output logic coproDoubleClock,
  output logic coproPhaseClock,
  output logic coproAddrStrobeOutN,
  input wire logic coproReadyInN,
  // Static configuration
  input wire logic halfSpeed
);

  chs_pkg::chs_regs_t st_q;
  chs_pkg::chs_regs_t st_d;
  chs_pkg::chs_pins_t pins;
  logic primaryRise;
  logic phaseRise;
  logic coproRise;

  assign pins = '{primaryDoubleClock, sysPhaseClock, cpuAddrStrobeN,
                  coproReadyInN, halfSpeed};
  assign primaryRise = st_q.sync2.primaryDoubleClock & ~st_q.prevDouble;
  assign phaseRise = st_q.sync2.sysPhaseClock & ~st_q.prevPhase;
  assign coproRise = st_q.halfMode & primaryRise & ~st_q.doubleOut;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.sync1 = pins;
    st_d.sync2 = st_q.sync1;
    st_d.prevDouble = st_q.sync2.primaryDoubleClock;
    st_d.prevPhase = st_q.sync2.sysPhaseClock;
    if (st_q.halfMode) begin
      if (primaryRise) begin
        st_d.doubleOut = ~st_q.doubleOut; // RL2
      end
      if (phaseRise) begin
        st_d.phaseOut = ~st_q.phaseOut; // RL4
      end
    end else begin
      st_d.doubleOut = st_q.sync2.primaryDoubleClock; // RL1
      st_d.phaseOut = st_q.sync2.sysPhaseClock; // RL3
    end
    case (st_q.state)
      chs_pkg::CHS_IDLE: begin
        st_d.halfMode = st_q.sync2.halfSpeed; // RL10
        if (st_q.halfMode != st_q.sync2.halfSpeed) begin
          // Mode change restarts the divided clocks low
          st_d.doubleOut = chs_pkg::RST_CLOCK;
          st_d.phaseOut = chs_pkg::RST_CLOCK;
        end else if (st_q.halfMode && !st_q.sync2.cpuAddrStrobeN) begin
          st_d.strobeOutN = 1'h0; // RL6
          st_d.edgeCnt = 2'h0;
          st_d.state = chs_pkg::CHS_STROBE;
        end
      end
      chs_pkg::CHS_STROBE: begin
        if (coproRise) begin
          st_d.edgeCnt = st_q.edgeCnt + 2'h1;
          if (st_q.edgeCnt + 2'h1 == chs_pkg::STROBE_EDGES) begin
            st_d.strobeOutN = 1'h1; // RL6
            st_d.state = chs_pkg::CHS_WAIT;
          end
        end
      end
      chs_pkg::CHS_WAIT: begin
        if (coproRise && !st_q.sync2.coproReadyInN) begin
          st_d.readyOutN = 1'h0; // RL7 RL8
          st_d.state = chs_pkg::CHS_READY;
        end
      end
      chs_pkg::CHS_READY: begin
        if (primaryRise) begin
          st_d.readyOutN = 1'h1; // RL8
          st_d.state = chs_pkg::CHS_IDLE;
        end
      end
      default: begin
        st_d.state = chs_pkg::CHS_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
      st_q.sync1.cpuAddrStrobeN <= 1'h1;
      st_q.sync2.cpuAddrStrobeN <= 1'h1;
      st_q.sync1.coproReadyInN <= 1'h1;
      st_q.sync2.coproReadyInN <= 1'h1;
      st_q.halfMode <= chs_pkg::RST_HALF;
      st_q.doubleOut <= chs_pkg::RST_CLOCK;
      st_q.phaseOut <= chs_pkg::RST_CLOCK;
      st_q.strobeOutN <= chs_pkg::RST_STROBE_N;
      st_q.readyOutN <= chs_pkg::RST_READY_N;
      st_q.state <= chs_pkg::CHS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign coproDoubleClock = st_q.doubleOut;
  assign coproPhaseClock = st_q.phaseOut;
  assign coproAddrStrobeOutN = st_q.strobeOutN;
  assign cpuReadyFromCoproN = st_q.readyOutN;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // A forwarded cycle is under way; the mode is frozen meanwhile
  logic cycleBusy;
  assign cycleBusy = st_q.state != chs_pkg::CHS_IDLE;

  sequence strobeStart;
    st_q.state == chs_pkg::CHS_IDLE && st_q.halfMode &&
      st_q.halfMode == st_q.sync2.halfSpeed && !st_q.sync2.cpuAddrStrobeN;
  endsequence

  sequence strobeHeld;
    !coproAddrStrobeOutN && st_q.state == chs_pkg::CHS_STROBE;
  endsequence

  sequence readyTaken;
    st_q.state == chs_pkg::CHS_WAIT && coproRise &&
      !st_q.sync2.coproReadyInN;
  endsequence

  sequence readyHeld;
    !cpuReadyFromCoproN && st_q.state == chs_pkg::CHS_READY;
  endsequence

  // ****************************************
  // Clock checks
  // ****************************************
  full_double_a: assert property (!st_q.halfMode && // RL1
    $stable(st_q.halfMode) |->
    coproDoubleClock == $past(st_q.sync2.primaryDoubleClock))
    else $error("double clock does not follow primary at full speed");

  half_double_a: assert property (st_q.halfMode && primaryRise && // RL2
    cycleBusy |=> coproDoubleClock != $past(coproDoubleClock))
    else $error("double clock did not toggle at half speed");

  half_hold_a: assert property (st_q.halfMode && !primaryRise && // RL2
    cycleBusy |=> $stable(coproDoubleClock))
    else $error("double clock moved without a primary edge");

  full_phase_a: assert property (!st_q.halfMode && // RL3
    $stable(st_q.halfMode) |->
    coproPhaseClock == $past(st_q.sync2.sysPhaseClock))
    else $error("phase clock does not follow system phase at full speed");

  half_phase_a: assert property (st_q.halfMode && !phaseRise && // RL4
    cycleBusy |=> $stable(coproPhaseClock))
    else $error("phase clock moved without a system phase edge");

  phase_toggle_a: assert property (st_q.halfMode && phaseRise && // RL4
    cycleBusy |=> coproPhaseClock != $past(coproPhaseClock))
    else $error("phase clock did not toggle at half speed");

  // ****************************************
  // Strobe checks
  // ****************************************
  strobe_start_a: assert property (strobeStart |=> strobeHeld) // RL6
    else $error("address strobe not driven after cpu strobe");

  strobe_stay_a: assert property (st_q.state == chs_pkg::CHS_STROBE && // RL6
    !coproRise |=> strobeHeld)
    else $error("address strobe ended before its coprocessor edges");

  strobe_end_a: assert property (st_q.state == chs_pkg::CHS_STROBE && // RL6
    coproRise && st_q.edgeCnt == chs_pkg::STROBE_EDGES - 2'h1 |=>
    coproAddrStrobeOutN && st_q.state == chs_pkg::CHS_WAIT)
    else $error("address strobe not released after its edges");

  strobe_full_a: assert property (!st_q.halfMode |-> // RL6
    coproAddrStrobeOutN)
    else $error("address strobe active at full speed");

  // ****************************************
  // Ready checks
  // ****************************************
  ready_pace_a: assert property (st_q.state == chs_pkg::CHS_WAIT && // RL7
    !(coproRise && !st_q.sync2.coproReadyInN) |=> cpuReadyFromCoproN)
    else $error("cpu ready given without coprocessor ready");

  ready_give_a: assert property (readyTaken |=> readyHeld) // RL7
    else $error("cpu ready missing after coprocessor ready");

  ready_hold_a: assert property (st_q.state == chs_pkg::CHS_READY && // RL8
    !primaryRise |=> readyHeld)
    else $error("cpu ready dropped before a primary edge");

  ready_end_a: assert property (st_q.state == chs_pkg::CHS_READY && // RL8
    primaryRise |=> cpuReadyFromCoproN && !cycleBusy)
    else $error("cpu ready not ended at the primary edge");

  ready_pulse_a: assert property ($fell(cpuReadyFromCoproN) |-> // RL8
    st_q.state == chs_pkg::CHS_READY && st_q.halfMode)
    else $error("cpu ready outside a half-speed cycle");

  // ****************************************
  // Mode checks
  // ****************************************
  mode_static_a: assert property ($changed(st_q.halfMode) |-> // RL10
    $past(st_q.state) == chs_pkg::CHS_IDLE)
    else $error("speed mode changed during a cycle");

  mode_restart_a: assert property (!cycleBusy && // RL10
    st_q.halfMode != st_q.sync2.halfSpeed |=>
    !coproDoubleClock && !coproPhaseClock)
    else $error("clocks not restarted low on a mode change");

  full_idle_a: assert property (!st_q.halfMode |-> !cycleBusy) // RL10
    else $error("forwarded cycle running at full speed");

endmodule

// ===== src/chs_pkg.sv
// Shared types and constants of the coprocessor half-speed port
package chs_pkg;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_CLOCK = 1'h0;
  localparam logic RST_STROBE_N = 1'h1;
  localparam logic RST_READY_N = 1'h1;
  localparam logic RST_HALF = 1'h0;

  // ****************************************
  // Timing counts, in coprocessor clock edges
  // ****************************************
  localparam logic [1:0] STROBE_EDGES = 2'h2;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CHS_IDLE = 2'h0,
    CHS_STROBE = 2'h1,
    CHS_WAIT = 2'h3,
    CHS_READY = 2'h2
  } chs_state_t;

  typedef struct packed {
    logic primaryDoubleClock;
    logic sysPhaseClock;
    logic cpuAddrStrobeN;
    logic coproReadyInN;
    logic halfSpeed;
  } chs_pins_t;

  typedef struct packed {
    chs_pins_t sync1;
    chs_pins_t sync2;
    logic prevDouble;
    logic prevPhase;
    logic halfMode;
    logic doubleOut;
    logic phaseOut;
    logic strobeOutN;
    logic readyOutN;
    logic [1:0] edgeCnt;
    chs_state_t state;
  } chs_regs_t;

endpackage

// ===== tb/chs_copro_model.sv
// Behavioural coprocessor answering forwarded cycles with its ready
`timescale 1ns/1ns

module chs_copro_model (
  // Clock, reset and pacing
  input wire logic coproDoubleClock,
  input wire logic rst,
  input wire logic [3:0] waitRises,
  // Cycle handshake
  input wire logic coproAddrStrobeOutN,
  output logic coproReadyInN
);
  logic armed = 1'h1;
  logic [4:0] cnt = 5'h00;
  // Strobe as it stood just before each coprocessor clock edge
  logic strobeSeenN = 1'h1;
  initial coproReadyInN = 1'h1;
  always @(coproAddrStrobeOutN) strobeSeenN <= #1 coproAddrStrobeOutN;
  // Reset taken on the coprocessor's own clock
  always @(posedge coproDoubleClock) begin
    coproReadyInN <= 1'h1;
    if (rst) begin
      armed <= 1'h1;
      cnt <= 5'h00;
    end else if (armed && !strobeSeenN) begin
      armed <= 1'h0;
      cnt <= {1'h0, waitRises} + 5'h01;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      coproReadyInN <= (cnt != 5'h01);
    end else if (strobeSeenN) begin
      armed <= 1'h1;
    end
  end
endmodule

// ===== tb/chs_port_tb.sv
// Self-checking bench of the coprocessor half-speed port
`timescale 1ns/1ns

module chs_port_tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic primaryDoubleClock = 1'h0;
  logic sysPhaseClock = 1'h0;
  logic cpuAddrStrobeN = 1'h1;
  logic halfSpeed = 1'h0;
  logic [3:0] waitRises = 4'h0;
  logic cpuReadyFromCoproN, coproDoubleClock, coproPhaseClock;
  logic coproAddrStrobeOutN, coproReadyInN;
  logic prevD = 1'h0, prevP = 1'h0, prevS = 1'h1, prevR = 1'h1;
  int seed = 71, n_errors = 0, compares = 0, cyc = 0, i, k, a, b;
  int dRise = 0, pRise = 0, sRise = 0, sLow = 0, mLow = 0, rLow = 0;
  int mAtReady = 0;
  logic coproRst = 1'h1;
  chs_port dut_u (.clock(clock), .rst(rst),
    .primaryDoubleClock(primaryDoubleClock), .sysPhaseClock(sysPhaseClock),
    .cpuAddrStrobeN(cpuAddrStrobeN), .cpuReadyFromCoproN(cpuReadyFromCoproN),
    .coproDoubleClock(coproDoubleClock), .coproPhaseClock(coproPhaseClock),
    .coproAddrStrobeOutN(coproAddrStrobeOutN),
    .coproReadyInN(coproReadyInN), .halfSpeed(halfSpeed));
  chs_copro_model copro_u (.coproDoubleClock(coproDoubleClock),
    .rst(coproRst), .waitRises(waitRises),
    .coproAddrStrobeOutN(coproAddrStrobeOutN),
    .coproReadyInN(coproReadyInN));
  // Coprocessor reset retimed to its own double clock
  always @(posedge coproDoubleClock) coproRst <= rst;
  always #50 clock = ~clock;
  // Link clocks of 800 ns and 1600 ns, plus output watchers
  always @(negedge clock) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) primaryDoubleClock <= ~primaryDoubleClock;
    if (cyc % 8 == 7) sysPhaseClock <= ~sysPhaseClock;
    prevD <= coproDoubleClock;
    prevP <= coproPhaseClock;
    prevS <= coproAddrStrobeOutN;
    prevR <= cpuReadyFromCoproN;
    if (coproDoubleClock && !prevD) dRise <= dRise + 1;
    if (coproPhaseClock && !prevP) pRise <= pRise + 1;
    if (coproDoubleClock && !prevD && !prevS) sRise <= sRise + 1;
    if (!coproAddrStrobeOutN) sLow <= sLow + 1;
    if (!coproReadyInN) mLow <= mLow + 1;
    if (!cpuReadyFromCoproN) rLow <= rLow + 1;
    if (!cpuReadyFromCoproN && prevR) mAtReady <= mLow;
  end
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  task summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wait_low(input logic half);
    for (i = 0; i < 400; i++) begin
      @(negedge clock);
      if ((half ? coproAddrStrobeOutN : cpuReadyFromCoproN) === 1'h0) break;
    end
    if (i >= 400) begin
      n_errors++;
      $display("FAIL wait expected low seen timeout");
      summarize();
    end
  endtask
  // Count output clock rises over 32 primary periods
  task window(input logic [7:0] expD, input logic [7:0] expP);
    repeat (40) @(negedge clock);
    a = dRise;
    b = pRise;
    repeat (256) @(negedge clock);
    check("double rises", 8'(dRise - a), expD);
    check("phase rises", 8'(pRise - b), expP);
  endtask
  task cycle_half;
    a = mLow;
    b = sRise;
    repeat ($unsigned($random(seed)) % 8) @(negedge clock);
    cpuAddrStrobeN = 1'h0;
    wait_low(1'h1);
    cpuAddrStrobeN = 1'h1;
    wait_low(1'h0);
    @(negedge clock);
    check("ready after copro", 8'(mAtReady > a), 8'h01);
    repeat (40) @(negedge clock);
    check("strobe rises", 8'(sRise - b), 8'h02);
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'h0;
    window(8'h20, 8'h10);
    a = sLow;
    b = rLow;
    cpuAddrStrobeN = 1'h0;
    repeat (20) @(negedge clock);
    cpuAddrStrobeN = 1'h1;
    repeat (40) @(negedge clock);
    check("full strobe", 8'(sLow - a), 8'h00);
    check("full ready", 8'(rLow - b), 8'h00);
    halfSpeed = 1'h1;
    window(8'h10, 8'h08);
    for (k = 0; k < 5; k++) begin
      waitRises = (k == 0) ? 4'h0 : 4'(($unsigned($random(seed)) % 4));
      cycle_half();
    end
    halfSpeed = 1'h0;
    window(8'h20, 8'h10);
    summarize();
  end
endmodule
